// ---- rtl/rom_pin_share_pkg.sv ----
// Constants for the expansion ROM / indicator / serial PROM pin sharing block.
// Assumes a single 125 MHz core clock driving every consumer of this package.
package rom_pin_share_pkg;
    localparam int ROM_ADDR_WIDTH = 16;
    localparam int ROM_DATA_WIDTH = 8;
    localparam int LOW_PIN_COUNT  = 8;
    // Pin positions within the address bus
    localparam int POS_LINK10     = 15;
    localparam int POS_LINK100    = 14;
    localparam int POS_IO1        = 7;
    localparam int POS_IO0        = 6;
    localparam int POS_PROM_DOUT  = 5;
    localparam int POS_PROM_CLK   = 4;
    localparam int POS_PROM_DIN   = 3;
    localparam int POS_POWER      = 2;
    localparam int POS_LINKGIG    = 1;
    localparam int POS_DUPLEX     = 0;
    // Timing
    localparam int CLK_FREQ_KHZ   = 125000;
    localparam int PROM_CLK_KHZ   = 150;
    // Half period of the serial PROM clock, rounded down so the rate never falls below 150 kHz
    localparam int PROM_HALF_CYC  = CLK_FREQ_KHZ / (2 * PROM_CLK_KHZ);
    localparam int ROM_STROBE_CYC = 4;
    // Strap counter value at which both synchroniser stages hold the straps
    localparam int STRAP_SETTLE   = 2;
endpackage

// ---- rtl/rom_pin_share.sv ----
// Pin sharing between the expansion ROM address/data port and the
// indicator, general I/O and serial PROM functions, plus reset and straps.
// Assumes pin inputs are asynchronous and pass two flops before use.
`timescale 1ns/100ps

// What this block does
// - Pin 15: address bit or 10M link indicator
// - Pin 14: address bit or 100M link indicator
// - Middle address pins carry only access address, driven low when idle
// - Pin 7: address bit or general I/O 1
// - Pin 6: address bit or general I/O 0
// - Pin 5: address bit or PROM data input
// - Pin 4: address bit or 150 kHz PROM clock
// - Pin 3: address bit or PROM serial data
// - Pin 2: address bit or power indicator
// - Pin 1: address bit or gigabit indicator
// - Pin 0: address bit or duplex indicator
// - Eight-bit data bus, driven only on writes
// - Reset output follows own reset
// - Test strap high in reset selects test
// - Mode strap high GMII, low ten-bit
// - Everything clocked from the 125 MHz clock
// - PROM select asserted during PROM access
module rom_pin_share #(
    parameter int STROBE_CYCLES = rom_pin_share_pkg::ROM_STROBE_CYC,
    parameter int PROM_HALF     = rom_pin_share_pkg::PROM_HALF_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // ROM access requests from the register window
    input  wire logic        romReq,
    input  wire logic        romWrite,
    input  wire logic [15:0] romAddr,
    input  wire logic [7:0]  romWrData,
    output logic             romBusy,
    output logic             romDone,
    output logic [7:0]       romRdData,
    // Indicator sources, active low
    input  wire logic        link10Src_n,
    input  wire logic        link100Src_n,
    input  wire logic        linkGigSrc_n,
    input  wire logic        powerSrc_n,
    input  wire logic        duplexSrc_n,
    // General I/O control
    input  wire logic [1:0]  gpioOut,
    input  wire logic [1:0]  gpioOe,
    output logic [1:0]       gpioIn,
    // Serial PROM control
    input  wire logic        promEnable,
    input  wire logic        promDataOut,
    output logic             promDataIn,
    output logic             promClockRise,
    // Shared address pins
    output logic [15:0]      addrPinOut,
    output logic [15:0]      addrPinOe,
    input  wire logic [15:0] addrPinIn,
    // ROM data pins and strobes
    output logic [7:0]       dataPinOut,
    output logic             dataPinOe,
    input  wire logic [7:0]  dataPinIn,
    output logic             romWriteStrobe_n,
    output logic             romReadStrobe_n,
    output logic             promSelect,
    // Reset and straps
    output logic             boardResetOut,
    input  wire logic        testStrap,
    input  wire logic        modeStrap,
    output logic             testMode,
    output logic             gmiiMode
);
    typedef enum logic [1:0] {IDLE, STROBE, FINISH} rom_state_type;

    rom_state_type state_reg, state_next;
    logic [15:0] addr_reg;
    logic [7:0]  wdata_reg, rdata_reg;
    logic        write_reg;
    logic [7:0]  cnt_reg;
    logic [15:0] pinSync1_reg, pinSync2_reg;
    logic [7:0]  dataSync1_reg, dataSync2_reg;
    logic [1:0]  strapSync1_reg, strapSync2_reg;
    logic [1:0]  strapCnt_reg;
    logic        testMode_reg, gmii_reg;
    logic [15:0] promCnt_reg;
    logic        promClk_reg;
    logic        romActive;
    logic        strobeEnd;
    logic [15:0] funcOut, funcOe;

    // An access owns the pins from the take edge until FINISH has passed
    assign romActive = (state_reg != IDLE);
    assign strobeEnd = (state_reg == STROBE) && (cnt_reg == 8'(STROBE_CYCLES - 1));

    // ROM access sequencer: one request, a fixed strobe, then release
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IDLE:    if (romReq) state_next = STROBE;
            STROBE:  if (strobeEnd) state_next = FINISH;
            FINISH:  state_next = IDLE;
            default: state_next = IDLE;
        endcase
    end

    // Request fields are latched at the take edge, so the host may change
    // them while the access runs; requests during an access are ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= IDLE;
            addr_reg  <= 16'h0000;
            wdata_reg <= 8'h00;
            write_reg <= 1'b0;
            cnt_reg   <= 8'h00;
            rdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= (state_reg == STROBE) ? cnt_reg + 8'h01 : 8'h00;
            if (state_reg == IDLE && romReq) begin
                addr_reg  <= romAddr;
                wdata_reg <= romWrData;
                write_reg <= romWrite;
            end
            // Sample read data late in the strobe, after ROM access time
            if (strobeEnd && !write_reg)
                rdata_reg <= dataSync2_reg;
        end
    end

    // Handshake outputs decode the state directly
    assign romBusy   = romActive;
    assign romDone   = (state_reg == FINISH);
    assign romRdData = rdata_reg;

    // Strobes are exclusive by construction: one decodes write, the other read
    assign romWriteStrobe_n = !((state_reg == STROBE) && write_reg);
    assign romReadStrobe_n  = !((state_reg == STROBE) && !write_reg);
    assign dataPinOut = wdata_reg;
    assign dataPinOe  = romActive && write_reg;

    // Input synchronisers for shared pins, data bus and straps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1_reg   <= 16'h0000;
            pinSync2_reg   <= 16'h0000;
            dataSync1_reg  <= 8'h00;
            dataSync2_reg  <= 8'h00;
            strapSync1_reg <= 2'h0;
            strapSync2_reg <= 2'h0;
        end else begin
            pinSync1_reg   <= addrPinIn;
            pinSync2_reg   <= pinSync1_reg;
            dataSync1_reg  <= dataPinIn;
            dataSync2_reg  <= dataSync1_reg;
            strapSync1_reg <= {testStrap, modeStrap};
            strapSync2_reg <= strapSync1_reg;
        end
    end

    // Straps are taken once, on the edge after the second synchroniser flop
    // holds them; a strap that moves later is ignored until the next reset,
    // so the board must keep them steady around reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strapCnt_reg <= 2'h0;
            testMode_reg <= 1'b0;
            gmii_reg     <= 1'b0;
        end else begin
            if (strapCnt_reg != 2'h3)
                strapCnt_reg <= strapCnt_reg + 2'h1;
            if (strapCnt_reg == 2'(rom_pin_share_pkg::STRAP_SETTLE)) begin
                testMode_reg <= strapSync2_reg[1];
                gmii_reg     <= strapSync2_reg[0];
            end
        end
    end
    assign testMode = testMode_reg;
    assign gmiiMode = gmii_reg;

    // Board reset simply mirrors our own reset, so it holds through it
    assign boardResetOut = !rst_n;

    // Serial PROM clock divider, held still while the PROM is idle
    // Clearing it on every ROM access keeps the PROM from clocking on address bit 4
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            promCnt_reg <= 16'h0000;
            promClk_reg <= 1'b0;
        end else if (!promEnable || romActive) begin
            promCnt_reg <= 16'h0000;
            promClk_reg <= 1'b0;
        end else if (promCnt_reg == 16'(PROM_HALF - 1)) begin
            promCnt_reg <= 16'h0000;
            promClk_reg <= !promClk_reg;
        end else begin
            promCnt_reg <= promCnt_reg + 16'h0001;
        end
    end
    assign promClockRise = promEnable && !romActive && !promClk_reg
                           && (promCnt_reg == 16'(PROM_HALF - 1));
    assign promSelect = promEnable && !romActive;

    // Own functions of the shared pins when no ROM access is running
    always_comb begin
        funcOut = 16'h0000;
        funcOe  = 16'h0000;
        funcOut[rom_pin_share_pkg::POS_LINK10]    = link10Src_n;
        funcOut[rom_pin_share_pkg::POS_LINK100]   = link100Src_n;
        funcOut[rom_pin_share_pkg::POS_IO1]       = gpioOut[1];
        funcOut[rom_pin_share_pkg::POS_IO0]       = gpioOut[0];
        funcOut[rom_pin_share_pkg::POS_PROM_CLK]  = promClk_reg;
        funcOut[rom_pin_share_pkg::POS_PROM_DIN]  = promSelect && promDataOut;
        funcOut[rom_pin_share_pkg::POS_POWER]     = powerSrc_n;
        funcOut[rom_pin_share_pkg::POS_LINKGIG]   = linkGigSrc_n;
        funcOut[rom_pin_share_pkg::POS_DUPLEX]    = duplexSrc_n;
        funcOe = 16'hFFFF;
        funcOe[rom_pin_share_pkg::POS_IO1]        = gpioOe[1];
        funcOe[rom_pin_share_pkg::POS_IO0]        = gpioOe[0];
        funcOe[rom_pin_share_pkg::POS_PROM_DOUT]  = 1'b0;
    end

    // Address owns every pin during an access; middle bits are address only
    // Pin 5 and idle general I/O bits are the only pins ever released
    assign addrPinOut = romActive ? addr_reg : funcOut;
    assign addrPinOe  = romActive ? 16'hFFFF : funcOe;

    assign gpioIn     = {pinSync2_reg[rom_pin_share_pkg::POS_IO1],
                         pinSync2_reg[rom_pin_share_pkg::POS_IO0]};
    assign promDataIn = pinSync2_reg[rom_pin_share_pkg::POS_PROM_DOUT];

    // Checks
    a_strobe_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
        !(!romWriteStrobe_n && !romReadStrobe_n)) else $error("both ROM strobes low");
    a_addr_during_access: assert property (@(posedge clk) disable iff (!rst_n)
        romActive |-> addrPinOut == addr_reg && addrPinOe == 16'hFFFF)
        else $error("address not on pins during access");
    a_link10_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> addrPinOut[15] == link10Src_n) else $error("10M indicator wrong");
    a_link100_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> addrPinOut[14] == link100Src_n) else $error("100M indicator wrong");
    a_gpio_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> addrPinOe[7:6] == gpioOe && addrPinOut[7:6] == gpioOut)
        else $error("general I/O not on pins");
    a_prom_dout_input: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> !addrPinOe[5]) else $error("PROM data pin driven");
    a_led_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> addrPinOut[2:0] == {powerSrc_n, linkGigSrc_n, duplexSrc_n})
        else $error("indicator pins wrong");
    a_data_drive: assert property (@(posedge clk) disable iff (!rst_n)
        dataPinOe |-> write_reg && romActive) else $error("data bus driven on read");
    a_release_after: assert property (@(posedge clk) disable iff (!rst_n)
        romDone |=> !romBusy) else $error("access did not release pins");
    a_strobe_length: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_reg == STROBE) |-> (state_reg == STROBE) [*4] ##1 romDone)
        else $error("strobe length wrong");
    a_prom_select: assert property (@(posedge clk) disable iff (!rst_n)
        promSelect |-> promEnable && !romActive) else $error("PROM select wrong");
    a_reset_out: assert property (@(posedge clk)
        rst_n |-> !boardResetOut) else $error("reset output stuck");

    // Idle functions of the remaining shared pins, and pin 5 during an access
    a_gig_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> addrPinOut[1] == linkGigSrc_n)
        else $error("gigabit indicator wrong");
    a_duplex_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> addrPinOut[0] == duplexSrc_n)
        else $error("duplex indicator wrong");
    a_prom_din_pin: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> addrPinOut[3] == (promEnable && promDataOut))
        else $error("PROM serial data pin wrong");
    a_prom_clk_pin: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> addrPinOut[4] == promClk_reg && addrPinOe[4])
        else $error("PROM clock not on its pin");
    a_pin5_during: assert property (@(posedge clk) disable iff (!rst_n)
        romActive |-> addrPinOe[5])
        else $error("PROM data pin not turned to address");

    // Serial PROM clock: bounded half period, still during ROM accesses;
    // a rise pulse must be followed by the clock going high
    a_prom_clk_still: assert property (@(posedge clk) disable iff (!rst_n)
        romActive |=> !promClk_reg)
        else $error("PROM clock moved during ROM access");
    a_prom_rise_next: assert property (@(posedge clk) disable iff (!rst_n)
        promClockRise |=> promClk_reg)
        else $error("PROM clock did not rise after pulse");
    a_prom_rise_select: assert property (@(posedge clk) disable iff (!rst_n)
        promClockRise |-> promSelect)
        else $error("PROM clock rise without select");
    a_prom_half_bound: assert property (@(posedge clk) disable iff (!rst_n)
        promCnt_reg < 16'(PROM_HALF))
        else $error("PROM divider overran its half period");
    a_prom_select_off: assert property (@(posedge clk) disable iff (!rst_n)
        romActive |-> !promSelect)
        else $error("PROM selected during ROM access");

    // ROM strobes and the data bus direction
    a_read_strobe_read: assert property (@(posedge clk) disable iff (!rst_n)
        !romReadStrobe_n |-> romActive && !write_reg && !dataPinOe)
        else $error("read strobe outside a read");
    a_write_strobe_write: assert property (@(posedge clk) disable iff (!rst_n)
        !romWriteStrobe_n |-> romActive && write_reg && dataPinOe)
        else $error("write strobe outside a write");
    a_strobes_finish: assert property (@(posedge clk) disable iff (!rst_n)
        romDone |-> romReadStrobe_n && romWriteStrobe_n)
        else $error("strobe still low while finishing");
    a_end_to_finish: assert property (@(posedge clk) disable iff (!rst_n)
        strobeEnd |=> romDone)
        else $error("strobe end not followed by finish");
    a_idle_release: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive |-> !dataPinOe && romReadStrobe_n && romWriteStrobe_n)
        else $error("ROM bus not released when idle");
    a_busy_done: assert property (@(posedge clk) disable iff (!rst_n)
        romDone |-> romBusy)
        else $error("finish without busy");
    a_done_single: assert property (@(posedge clk) disable iff (!rst_n)
        romDone |=> !romDone)
        else $error("finish longer than one cycle");

    // Request capture and the latched address
    a_take_request: assert property (@(posedge clk) disable iff (!rst_n)
        !romActive && romReq |=> romActive && addr_reg == $past(romAddr))
        else $error("request not taken");
    a_addr_held: assert property (@(posedge clk) disable iff (!rst_n)
        romActive |=> $stable(addr_reg))
        else $error("address changed during access");
    a_rdata_kept: assert property (@(posedge clk) disable iff (!rst_n)
        !strobeEnd |=> $stable(rdata_reg))
        else $error("read data changed outside a read");

    // Straps: taken once from the second synchroniser flop, then frozen
    a_strap_capture: assert property (@(posedge clk) disable iff (!rst_n)
        strapCnt_reg == 2'(rom_pin_share_pkg::STRAP_SETTLE)
        |=> {testMode_reg, gmii_reg} == $past(strapSync2_reg))
        else $error("straps not captured");
    a_straps_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        strapCnt_reg == 2'h3 |=> $stable(testMode_reg) && $stable(gmii_reg))
        else $error("strap modes changed after capture");
endmodule // rom_pin_share

// ---- test/rom_prom_model.sv ----
// Far-side model: parallel ROM on the shared pins, serial PROM data line, pull-ups.
// Assumes the device drives address and strobes on its clock and releases the data bus on reads.
`timescale 1ns/100ps
module rom_prom_model (
    // Clock
    input  wire logic        clk,
    // Device pins
    input  wire logic [15:0] addrPinOut,
    input  wire logic [15:0] addrPinOe,
    input  wire logic [7:0]  dataPinOut,
    input  wire logic        dataPinOe,
    input  wire logic        romWriteStrobe_n,
    input  wire logic        romReadStrobe_n,
    input  wire logic        promBit,
    output logic [15:0]      addrPinIn,
    output logic [7:0]       dataPinIn
);
    logic [7:0] mem [0:65535];
    logic [7:0] lastRd = 8'h00;
    // Undriven pins: PROM data on pin 5, pull-ups on the rest
    assign addrPinIn = (addrPinOe & addrPinOut) | (~addrPinOe & {10'h3FF, promBit, 5'h1F});
    // ROM takes the byte while its write strobe is low
    always @(negedge clk) begin
        if (!romWriteStrobe_n && dataPinOe) mem[addrPinOut] <= dataPinOut;
        if (!romReadStrobe_n) lastRd <= mem[addrPinOut];
    end
    // Released bus shows the inverse of the last byte, so a stale value cannot pass
    assign dataPinIn = !romReadStrobe_n ? mem[addrPinOut] : ~lastRd;
endmodule // rom_prom_model

// ---- test/tb.sv ----
// Testbench for the ROM / indicator / serial PROM pin sharing block.
// Assumes inputs change at the falling edge and the PROM clock half period is shortened to 2.
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0, rst_n = 1'b0, romReq = 1'b0, romWrite = 1'b0, romBusy, romDone;
    logic [15:0] romAddr = 16'h0000, addrPinOut, addrPinOe, addrPinIn;
    logic [7:0]  romWrData = 8'h00, romRdData, dataPinOut, dataPinIn;
    logic l10 = 1'b1, l100 = 1'b1, lGig = 1'b1, pwr = 1'b1, dup = 1'b1;
    logic [1:0]  gpioOut = 2'h0, gpioOe = 2'h0, gpioIn;
    logic promEnable = 1'b0, promDataOut = 1'b0, promDataIn, promClockRise, promBit = 1'b0;
    logic dataPinOe, wrStb_n, rdStb_n, promSelect, boardResetOut, testMode, gmiiMode;
    logic testStrap = 1'b0, modeStrap = 1'b1, seen, rise, seenRise;
    int n_mismatch = 0, checks_done = 0;
    // Clock
    always #5 clk = ~clk;
    rom_pin_share #(.STROBE_CYCLES(4), .PROM_HALF(2)) i_dut (.clk(clk), .rst_n(rst_n),
        .romReq(romReq), .romWrite(romWrite), .romAddr(romAddr), .romWrData(romWrData),
        .romBusy(romBusy), .romDone(romDone), .romRdData(romRdData), .link10Src_n(l10),
        .link100Src_n(l100), .linkGigSrc_n(lGig), .powerSrc_n(pwr), .duplexSrc_n(dup),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn), .promEnable(promEnable),
        .promDataOut(promDataOut), .promDataIn(promDataIn), .promClockRise(promClockRise),
        .addrPinOut(addrPinOut), .addrPinOe(addrPinOe), .addrPinIn(addrPinIn),
        .dataPinOut(dataPinOut), .dataPinOe(dataPinOe), .dataPinIn(dataPinIn),
        .romWriteStrobe_n(wrStb_n), .romReadStrobe_n(rdStb_n), .promSelect(promSelect),
        .boardResetOut(boardResetOut), .testStrap(testStrap), .modeStrap(modeStrap),
        .testMode(testMode), .gmiiMode(gmiiMode));
    rom_prom_model i_rom (.clk(clk), .addrPinOut(addrPinOut), .addrPinOe(addrPinOe),
        .dataPinOut(dataPinOut), .dataPinOe(dataPinOe), .romWriteStrobe_n(wrStb_n),
        .romReadStrobe_n(rdStb_n), .promBit(promBit), .addrPinIn(addrPinIn),
        .dataPinIn(dataPinIn));
    // Compare and count
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Reset for 8 cycles with the given straps, then let them latch
    task automatic do_reset(input logic t, input logic m);
        testStrap = t;
        modeStrap = m;
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        chk(boardResetOut, 1'b1);
        chk({wrStb_n, rdStb_n, romBusy}, 3'b110);
        chk(addrPinOut[15], l10);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(boardResetOut, 1'b0);
        chk(testMode, t);
        chk(gmiiMode, m);
    endtask
    // Indicators follow their sources while no access runs
    task automatic t_leds(input logic [4:0] p);
        {l10, l100, pwr, lGig, dup} = p;
        @(negedge clk);
        chk({addrPinOut[15:14], addrPinOut[2:0]}, p);
        chk({addrPinOe[15:14], addrPinOe[2:0]}, 5'h1F);
    endtask
    // One ROM access, watched cycle by cycle
    task automatic rom_op(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        romReq = 1'b1;
        romWrite = w;
        romAddr = a;
        romWrData = d;
        @(negedge clk);
        romReq = 1'b0;
        for (n = 0; n < 20 && romDone !== 1'b1; n++) begin
            chk(addrPinOut, a);
            chk(addrPinOe, 16'hFFFF);
            chk(dataPinOe, w);
            chk(w ? rdStb_n : wrStb_n, 1'b1);
            chk({romBusy, w ? wrStb_n : rdStb_n}, 2'b10);
            @(negedge clk);
        end
        chk(romDone, 1'b1);
        @(negedge clk);
        chk({romBusy, addrPinOut[15], addrPinOut[0]}, {1'b0, l10, dup});
    endtask
    // Write two complementary addresses, read both back
    task automatic t_rom();
        rom_op(1'b1, 16'hA5C3, 8'h3C);
        rom_op(1'b1, 16'h5A3C, 8'hC3);
        rom_op(1'b0, 16'hA5C3, 8'h00);
        chk(romRdData, 8'h3C);
        rom_op(1'b0, 16'h5A3C, 8'h00);
        chk(romRdData, 8'hC3);
    endtask
    // General I/O drive and input on pins 7:6
    task automatic t_gpio();
        gpioOe = 2'b11;
        gpioOut = 2'b10;
        @(negedge clk);
        chk({addrPinOut[7:6], addrPinOe[7:6]}, 4'hB);
        gpioOe = 2'b00;
        repeat (3) @(negedge clk);
        chk({addrPinOe[7:6], gpioIn}, 4'h3);
    endtask
    // Serial PROM select, clock, data out and data in
    task automatic t_prom();
        promEnable = 1'b1;
        promDataOut = 1'b1;
        seen = 1'b0;
        seenRise = 1'b0;
        repeat (3) @(negedge clk);
        chk({promSelect, addrPinOut[3], promDataIn}, 3'h6);
        for (int i = 0; i < 10; i++) begin
            rise = promClockRise;
            @(negedge clk);
            if (addrPinOut[4] === 1'b1) seen = 1'b1;
            if (rise === 1'b1) begin
                seenRise = 1'b1;
                chk(addrPinOut[4], 1'b1);
            end
        end
        chk({seen, seenRise}, 2'h3);
        promBit = 1'b1;
        repeat (3) @(negedge clk);
        chk(promDataIn, 1'b1);
        promEnable = 1'b0;
    endtask
    // Watchdog
    initial begin
        #100us;
        n_mismatch++;
        summarize();
    end
    // Main sequence
    initial begin
        do_reset(1'b0, 1'b1);
        t_leds(5'b10110);
        t_leds(5'b01001);
        t_rom();
        t_gpio();
        t_prom();
        do_reset(1'b1, 1'b0);
        summarize();
    end
endmodule // tb
